// *** hw/galed_defines.svh ***
// timing constants for the gateway activity lamp driver
`ifndef GALED_DEFINES_SVH
`define GALED_DEFINES_SVH
`define GALED_CLK_HZ 32'h0773_5940
`define GALED_DARK_S 32'h0000_0014
`define GALED_TEST_S 32'h0000_0001
`define GALED_PULSE_MS 32'h0000_0032
// unsigned 32-bit arithmetic: the dark count does not fit a signed int
`define GALED_DARK_CYC (`GALED_DARK_S * `GALED_CLK_HZ)
`define GALED_TEST_CYC (`GALED_TEST_S * `GALED_CLK_HZ)
`define GALED_PULSE_CYC (`GALED_PULSE_MS * (`GALED_CLK_HZ / 32'h0000_03E8))
`endif

// *** hw/galed_driver.sv ***
// front-panel lamp driver: power-up sequence, traffic pulses, ethernet lamps
// Operation
// [R1] request/reply/error dark about twenty seconds
// [R2] then all three lit one second
// [R3] traffic lamps follow serial events only
// [R4] master errors, timeouts, flaws pulse error lamp
// [R5] slave exception response pulses error lamp
// [R6] request lamp per request sent/received
// [R7] master good response pulses reply lamp
// [R8] slave normal response pulses reply lamp
// [R9] activity lamp solid in boot, then blinks
// [R10] link lamp follows link presence
// [R11] pulses stretched, retriggered by new events
`timescale 1ns/100ps
`include "galed_defines.svh"
module galed_driver #(
  parameter int unsigned DARK_CYC = `GALED_DARK_CYC,
  parameter int unsigned TEST_CYC = `GALED_TEST_CYC,
  parameter int unsigned PULSE_CYC = `GALED_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input galed_pkg::galed_evt_s evt,
  input wire logic ethTraffic,
  input wire logic ethLinkPin,
  input wire logic bootBusy,
  output galed_pkg::galed_lamps_s lamps
);
  // elaboration-time guard: the stretch counters hold 24 bits, and zero
  // counts would wrap a phase counter round or give a pulse that never lights
  localparam bit timingBad = (DARK_CYC < 1) || (TEST_CYC < 1) || (PULSE_CYC < 1) ||
    (PULSE_CYC >= 32'h0100_0000);
  if (timingBad) begin : gen_bad_timing
    $error("galed_driver: bad timing parameter");
  end

  // pin-side ethernet status is asynchronous: two-stage synchronisers
  logic [1:0] trafSync_q;
  logic [1:0] linkSync_q;
  logic [1:0] bootSync_q;
  logic trafPrev_q;
  galed_pkg::galed_phase_e phase_q;
  logic [31:0] seqCnt_q;
  logic [23:0] reqCnt_q;
  logic [23:0] repCnt_q;
  logic [23:0] errCnt_q;
  logic [23:0] actCnt_q;
  galed_pkg::galed_lamps_s lamps_q;

  // events are same-domain strobes from the transaction engine
  // role bit is a level; strobes of the other role are simply not selected
  wire isMaster = evt.masterRole;

  // the role bit selects which strobe of each pair drives a lamp
  function automatic logic pick(input logic master, input logic asMaster, input logic asSlave);
    return master ? asMaster : asSlave;
  endfunction : pick

  wire reqHit = pick(isMaster, evt.reqSent, evt.reqRcvd); // [R6] [R3]
  wire repHit = pick(isMaster, evt.goodRespRcvd, evt.goodRespSent); // [R7] [R8]
  wire masterErr = evt.errCodeRcvd | evt.reqTimeout | evt.respFlawed; // [R4]
  wire errHit = pick(isMaster, masterErr, evt.exceptionSent); // [R4] [R5]
  // rising edge of the synchronised pin; a pin held high blinks only once
  wire trafEdge = trafSync_q[1] & ~trafPrev_q;
  wire running = (phase_q == galed_pkg::GALED_RUN);
  wire seqDone = (seqCnt_q == 32'h0000_0001);

  // retriggerable stretcher: a new event reloads the full width
  // a hit on the last cycle of a pulse simply extends it
  function automatic logic [23:0] stretch(input logic hit, input logic [23:0] cnt);
    if (hit)
      return PULSE_CYC[23:0]; // [R11]
    else if (cnt != 24'h00_0000)
      return cnt - 24'h00_0001;
    else
      return cnt;
  endfunction : stretch

  // a stretch counter that is not yet exhausted keeps its lamp lit
  function automatic logic lit(input logic [23:0] cnt);
    return cnt != 24'h00_0000;
  endfunction : lit

  // each pin gets its own two-flop chain; only stage two feeds any logic
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trafSync_q <= 2'h0;
    end else begin
      trafSync_q <= {trafSync_q[0], ethTraffic};
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      linkSync_q <= 2'h0;
    end else begin
      linkSync_q <= {linkSync_q[0], ethLinkPin};
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bootSync_q <= 2'h0;
    end else begin
      bootSync_q <= {bootSync_q[0], bootBusy};
    end
  end

  // resets to the idle level of the pin, so no false edge follows reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trafPrev_q <= 1'b0;
    end else begin
      trafPrev_q <= trafSync_q[1];
    end
  end

  // power-up sequencer; seqCnt counts down the current phase
  // each phase lasts exactly its count in cycles: the count is loaded on entry
  galed_pkg::galed_phase_e phase_d;
  logic [31:0] seqCnt_d;
  always_comb begin
    phase_d = phase_q;
    seqCnt_d = seqCnt_q;
    unique case (phase_q)
      galed_pkg::GALED_DARK: begin
        if (seqDone) begin
          phase_d = galed_pkg::GALED_TEST; // [R1]
          seqCnt_d = TEST_CYC;
        end else begin
          seqCnt_d = seqCnt_q - 32'h0000_0001;
        end
      end
      galed_pkg::GALED_TEST: begin
        if (seqDone) begin
          phase_d = galed_pkg::GALED_RUN; // [R2]
        end else begin
          seqCnt_d = seqCnt_q - 32'h0000_0001;
        end
      end
      galed_pkg::GALED_RUN: begin
        seqCnt_d = seqCnt_q;
      end
      // an illegal code restarts the whole power-up sequence
      default: begin
        phase_d = galed_pkg::GALED_DARK;
        seqCnt_d = DARK_CYC;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= galed_pkg::GALED_DARK;
      seqCnt_q <= DARK_CYC;
    end else begin
      phase_q <= phase_d;
      seqCnt_q <= seqCnt_d;
    end
  end

  // events before the run phase are ignored so the sequence stays clean
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reqCnt_q <= 24'h00_0000;
    end else begin
      reqCnt_q <= stretch(running & reqHit, reqCnt_q); // [R11]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      repCnt_q <= 24'h00_0000;
    end else begin
      repCnt_q <= stretch(running & repHit, repCnt_q); // [R11]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      errCnt_q <= 24'h00_0000;
    end else begin
      errCnt_q <= stretch(running & errHit, errCnt_q); // [R11]
    end
  end

  // activity blinks run in every phase, so traffic during boot shows as well
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      actCnt_q <= 24'h00_0000;
    end else begin
      actCnt_q <= stretch(trafEdge, actCnt_q); // [R9]
    end
  end

  wire testOn = (phase_q == galed_pkg::GALED_TEST);
  wire galed_pkg::galed_lamps_s lamps_d;
  // the lamp test overrides traffic; outside the run phase traffic lamps stay dark
  wire reqLit = testOn | (running & lit(reqCnt_q)); // [R1] [R2] [R6]
  wire repLit = testOn | (running & lit(repCnt_q)); // [R2] [R7] [R8]
  wire errLit = testOn | (running & lit(errCnt_q)); // [R2] [R4] [R5]
  // boot-busy overrides with solid light; otherwise brief blinks on traffic
  wire actLit = bootSync_q[1] | lit(actCnt_q); // [R9]
  assign lamps_d.request = reqLit;
  assign lamps_d.reply = repLit;
  assign lamps_d.error = errLit;
  assign lamps_d.ethActivity = actLit;
  // link presence is shown in every phase, independent of the sequencer
  assign lamps_d.ethLink = linkSync_q[1]; // [R10]

  // registered lamps: no decode glitch ever reaches a pin
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lamps_q <= '0;
    end else begin
      lamps_q <= lamps_d;
    end
  end

  assign lamps = lamps_q;
endmodule : galed_driver

// *** hw/galed_pkg.sv ***
// types for the gateway activity lamp driver
package galed_pkg;
  typedef enum logic [1:0] {
    GALED_DARK = 2'b00,
    GALED_TEST = 2'b01,
    GALED_RUN = 2'b10
  } galed_phase_e;
  typedef struct packed {
    logic masterRole;
    logic reqSent;
    logic reqRcvd;
    logic goodRespRcvd;
    logic errCodeRcvd;
    logic reqTimeout;
    logic respFlawed;
    logic goodRespSent;
    logic exceptionSent;
  } galed_evt_s;
  typedef struct packed {
    logic request;
    logic reply;
    logic error;
    logic ethActivity;
    logic ethLink;
  } galed_lamps_s;
endpackage : galed_pkg

// *** test/galed_driver_bench.sv ***
// self-checking bench for the lamp driver
`timescale 1ns/100ps
module galed_driver_bench;
  logic sys_clk = 1'b0, nrst = 1'b0, ethLinkPin = 1'b0, bootBusy = 1'b0, ethTraffic = 1'b0;
  galed_pkg::galed_evt_s evt;
  galed_pkg::galed_lamps_s lamps;
  int miscompares = 0, checks_done = 0, cyc = 0;
  always #4 sys_clk = ~sys_clk;
  galed_far_end far (.sys_clk, .evt);
  galed_driver #(.DARK_CYC(20), .TEST_CYC(10), .PULSE_CYC(5)) uut (.sys_clk, .nrst, .evt,
    .ethTraffic, .ethLinkPin, .bootBusy, .lamps);
  function automatic logic [2:0] want(logic m, int k);
    if (m) return k == 7 ? 3'h4 : k == 5 ? 3'h2 : (k > 1 && k < 5) ? 3'h1 : 3'h0;
    return k == 6 ? 3'h4 : k == 1 ? 3'h2 : k == 0 ? 3'h1 : 3'h0;
  endfunction : want
  task automatic check(string what, logic [2:0] seen, logic [2:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic ticks(int n);
    repeat (n) @(negedge sys_clk);
  endtask : ticks
  always @(posedge sys_clk) if (++cyc > 4000) begin
    miscompares++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hC7CE));
    ticks(16);
    nrst = 1'b1;
    far.fire(1'b1, 7);
    ticks(1);
    check("dark", lamps[4:2], 3'h0);
    ticks(22);
    check("test", lamps[4:2], 3'h7);
    ticks(12);
    check("after test", lamps[4:2], 3'h0);
    $display("power-up done");
    // first 18 passes sweep every role and strobe, the rest are random
    for (int i = 0; i < 60; i++) begin
      logic m;
      int k;
      m = i < 18 ? 1'(i / 9) : 1'($urandom);
      k = i < 18 ? i % 9 : int'($urandom % 9);
      far.fire(m, k);
      ticks(1);
      check("traffic", lamps[4:2], want(m, k));
      ticks(6);
      check("idle", lamps[4:2], 3'h0);
    end
    far.fire(1'b1, 7);
    ticks(2);
    far.fire(1'b1, 7);
    ticks(4);
    check("retrigger", lamps[4:2], 3'h4);
    $display("traffic done");
    ethLinkPin = 1'b1;
    bootBusy = 1'b1;
    ticks(5);
    check("link boot", {lamps.ethLink, lamps.ethActivity, 1'b0}, 3'h6);
    ethLinkPin = 1'b0;
    bootBusy = 1'b0;
    ticks(12);
    ethTraffic = 1'b1;
    ticks(4);
    check("blink", {lamps.ethLink, lamps.ethActivity, 1'b0}, 3'h2);
    check("serial quiet", lamps[4:2], 3'h0);
    ticks(6);
    check("blink end", {lamps.ethLink, lamps.ethActivity, 1'b0}, 3'h0);
    $display("ethernet done");
    wrap_up();
  end
endmodule : galed_driver_bench

// *** test/galed_far_end.sv ***
// serial engine model: one-cycle event strobes, role held as a level
`timescale 1ns/100ps
module galed_far_end (
  input logic sys_clk,
  output galed_pkg::galed_evt_s evt
);
  initial evt = '0;
  task automatic fire(input logic m, input int k);
    @(negedge sys_clk);
    evt = galed_pkg::galed_evt_s'({m, 8'h00} | (9'h001 << k));
    @(negedge sys_clk);
    evt = galed_pkg::galed_evt_s'({m, 8'h00});
  endtask : fire
endmodule : galed_far_end

// *** test/galed_monitor.sv ***
// assertion checker for the lamp driver, bound to its ports
`timescale 1ns/100ps
module galed_monitor #(
  parameter int unsigned DARK_CYC = 20,
  parameter int unsigned TEST_CYC = 10
) (
  input logic sys_clk,
  input logic nrst,
  input galed_pkg::galed_evt_s evt,
  input logic ethTraffic,
  input logic ethLinkPin,
  input logic bootBusy,
  input galed_pkg::galed_lamps_s lamps
);
  logic [31:0] cnt_q;
  wire m = evt.masterRole;
  // margin of four cycles so phase edges never meet a traffic check
  wire run = cnt_q >= 32'(DARK_CYC + TEST_CYC + 4);
  wire reqHit = m ? evt.reqSent : evt.reqRcvd;
  wire repHit = m ? evt.goodRespRcvd : evt.goodRespSent;
  wire errHit = m ? (evt.errCodeRcvd | evt.reqTimeout | evt.respFlawed) : evt.exceptionSent;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst) cnt_q <= 32'h0000_0000;
    else if (cnt_q != 32'hFFFF_FFFF) cnt_q <= cnt_q + 32'h0000_0001;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence held(b); b [*5]; endsequence
  dark_hold_a: assert property (cnt_q < DARK_CYC |-> lamps[4:2] == 3'h0)
    else $error("lamp lit while dark");
  lamp_test_a: assert property (cnt_q == 32'(DARK_CYC + 4) |-> lamps[4:2] == 3'h7)
    else $error("lamp test missing");
  req_pulse_a: assert property (run && reqHit |-> ##2 held(lamps.request))
    else $error("request pulse short");
  reply_pulse_a: assert property (run && repHit |-> ##2 held(lamps.reply))
    else $error("reply pulse short");
  error_pulse_a: assert property (run && errHit |-> ##2 held(lamps.error))
    else $error("error pulse short");
  req_idle_a: assert property (run ##0 !reqHit [*6] |=> !lamps.request)
    else $error("request lit without cause");
  link_follow_a: assert property (run ##0 $stable(ethLinkPin) [*4] |-> lamps.ethLink == ethLinkPin)
    else $error("link lamp wrong");
  act_blink_a: assert property (run && $rose(ethTraffic) |-> ##[1:5] lamps.ethActivity)
    else $error("activity blink missing");
endmodule : galed_monitor
bind galed_driver galed_monitor #(.DARK_CYC(DARK_CYC), .TEST_CYC(TEST_CYC)) chk (
  .sys_clk, .nrst, .evt, .ethTraffic, .ethLinkPin, .bootBusy, .lamps);
